// file: logic/fau_cfg.svh
// Purpose: Constants of the fault annunciator unit
// Assumes: APB byte addresses, 32-bit data, 10 MHz mclk
// Notes: Definitions only
`ifndef FAU_CFG_SVH
`define FAU_CFG_SVH

// Register byte offsets
`define FAU_OFS_CTRL 8'h00
`define FAU_OFS_STATUS 8'h04
`define FAU_OFS_RELAY0 8'h08
`define FAU_OFS_RELAY3 8'h14
`define FAU_OFS_IRQ_STAT 8'h18
`define FAU_OFS_IRQ_MASK 8'h1c
`define FAU_OFS_CHCFG0 8'h20

// Field positions
`define FAU_CTRL_EN_BIT 0
`define FAU_STAT_FLAG_BIT 0
`define FAU_STAT_WORD_LSB 16
`define FAU_CFG_EVAL_LSB 0
`define FAU_CFG_RELAY_LSB 16
`define FAU_CFG_TIMER_LSB 24
`define FAU_IRQ_SET_BIT 0
`define FAU_IRQ_CLR_BIT 1
`define FAU_IRQ_CFG_BIT 2

// Reset values
`define FAU_RST_CTRL 1'h0
`define FAU_RST_EVAL 15'h0001
`define FAU_RST_IRQ_MASK 3'h0

// Fault bank and timer ranges
`define FAU_RELAY_FIRST 16'h0384
`define FAU_RELAY_COUNT 100
`define FAU_TIMER_LAST 8'hc7

// Timing: evaluation tick in ms at the mclk rate in Hz
`define FAU_TICK_MS 100
`define FAU_MCLK_HZ 10000000
`define FAU_TICK_CYCLES (`FAU_TICK_MS * (`FAU_MCLK_HZ / 1000))

`endif

// file: logic/fau_pkg.sv
// Purpose: Types shared by the fault annunciator unit
// Assumes: Constants come from fau_cfg.svh
// Notes: None
package fau_pkg;

    // APB request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } fau_apb_req_s;

    // One timed-set channel
    typedef struct packed {
        logic [7:0] timer;
        logic [6:0] relay;
        logic [14:0] evalCount;
    } fau_chan_cfg_s;

endpackage

// file: logic/fau_eval_timers.sv
// Purpose: Evaluation timers of the timed-set channels
// Assumes: cmd is already synchronised to mclk
// Notes: Each timer owns its prescaler so the delay is never short
`timescale 1ns/1ps
`default_nettype none

module fau_eval_timers #(
    parameter int NUM_CH = 4,
    parameter int TICK_CYCLES = 1000000
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Per channel
    input wire logic [NUM_CH-1:0] cmd,
    input wire logic [NUM_CH-1:0][14:0] evalCount,
    output logic [NUM_CH-1:0] done
);
    import fau_pkg::*;

    localparam int SUBW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

    typedef struct packed {
        logic [NUM_CH-1:0][SUBW-1:0] sub;
        logic [NUM_CH-1:0][14:0] ticks;
    } fau_tmr_state_s;

    fau_tmr_state_s st;
    fau_tmr_state_s next_st;

    always_comb
    begin
        next_st = st;
        for (int ch = 0; ch < NUM_CH; ch++)
        begin
            done[ch] = cmd[ch] && (evalCount[ch] != 15'h0000)
                && (st.ticks[ch] >= evalCount[ch]);
            if (!cmd[ch])
            begin
                next_st.sub[ch] = '0;
                next_st.ticks[ch] = 15'h0000;
            end
            else if (st.ticks[ch] < evalCount[ch])
            begin
                if (st.sub[ch] == SUBW'(TICK_CYCLES - 1))
                begin
                    next_st.sub[ch] = '0;
                    next_st.ticks[ch] = st.ticks[ch] + 15'h0001;
                end
                else
                begin
                    next_st.sub[ch] = st.sub[ch] + SUBW'(1);
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            st <= '0;
        else
            st <= next_st;
    end

endmodule
`default_nettype wire

// file: logic/fau_lowest_fault.sv
// Purpose: Priority encoder over the fault relay bank
// Assumes: Bit 0 is the first fault relay
// Notes: Purely combinational
`timescale 1ns/1ps
`default_nettype none

module fau_lowest_fault #(
    parameter int N = 100
) (
    // Relay bank
    input wire logic [N-1:0] relays,
    // Result
    output logic any,
    output logic [6:0] lowIdx
);
    import fau_pkg::*;

    always_comb
    begin
        any = |relays;
        lowIdx = 7'h00;
        for (int i = N - 1; i >= 0; i--)
        begin
            if (relays[i])
                lowIdx = 7'(i);
        end
    end

endmodule
`default_nettype wire

// file: logic/fau_top.sv
// Purpose: Fault annunciator unit with APB registers
// Assumes: Command pins and the scan strobe are asynchronous to mclk
// Notes: Relays are set and cleared once per rising edge of the scan strobe
//
// Operation
// - Relay set after command held evaluation time
// - Early release clears timer, relay unset
// - Command release always resets its timer
// - Targets are the hundred fault relays
// - Flag and word valid only when enabled
// - Flag high while any relay on
// - Word holds lowest relay number on
// - Word moves on after lowest cleared
// - Clear removes only lowest active relay
// - Continuous clear: one relay per cycle
// - Pulse clear: one relay per assertion
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "fau_cfg.svh"

module fau_top #(
    parameter int NUM_SET = 4,
    parameter int TICK_CYCLES = `FAU_TICK_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // APB slave
    input wire fau_pkg::fau_apb_req_s apbReq,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Command and scan pins
    input wire logic opCycleStrobe,
    input wire logic [NUM_SET-1:0] timedFaultSet,
    input wire logic lowestFaultClear,
    input wire logic lowestFaultClearPulse,
    // Results
    output logic anyFaultActiveFlag,
    output logic [15:0] lowestActiveFaultWord,
    output logic [`FAU_RELAY_COUNT-1:0] faultRelays,
    output logic irq
);
    import fau_pkg::*;

    localparam int NR = `FAU_RELAY_COUNT;
    localparam int NIN = NUM_SET + 3;
    localparam int I_STROBE = NUM_SET;
    localparam int I_CONT = NUM_SET + 1;
    localparam int I_PULSE = NUM_SET + 2;

    typedef struct packed {
        logic [NIN-1:0] sync1;
        logic [NIN-1:0] sync2;
        logic strobePrev;
        logic pulsePrev;
        logic [NR-1:0] relays;
        logic enable;
        fau_chan_cfg_s [NUM_SET-1:0] cfg;
        logic [2:0] irqStatus;
        logic [2:0] irqMask;
        logic anyFlag;
        logic [15:0] lowWord;
        logic [31:0] prdata;
        logic pslverr;
    } fau_state_s;

    fau_state_s st;
    fau_state_s next_st;

    logic anyNow;
    logic [6:0] lowIdx;
    logic [NUM_SET-1:0] tmrDone;
    logic [NUM_SET-1:0][14:0] evalVec;
    logic strobeNow;
    logic pulseEdge;
    logic doClear;
    logic [NR-1:0] setMask;
    logic [NR-1:0] clrMask;
    logic [2:0] events;
    logic [127:0] relayPad;
    logic [31:0] readMux;
    logic mapped;
    logic wrTake;

    // Channel settings that software is allowed to give
    function automatic logic cfgValid(input fau_chan_cfg_s c);
        cfgValid = (c.evalCount != 15'h0000)
            && (c.relay < 7'(NR))
            && (c.timer <= `FAU_TIMER_LAST);
    endfunction

    function automatic fau_chan_cfg_s cfgUnpack(input logic [31:0] w);
        cfgUnpack.timer = w[`FAU_CFG_TIMER_LSB +: 8];
        cfgUnpack.relay = w[`FAU_CFG_RELAY_LSB +: 7];
        cfgUnpack.evalCount = w[`FAU_CFG_EVAL_LSB +: 15];
    endfunction

    always_comb
    begin
        for (int ch = 0; ch < NUM_SET; ch++)
            evalVec[ch] = st.cfg[ch].evalCount;
    end

    fau_eval_timers #(
        .NUM_CH(NUM_SET),
        .TICK_CYCLES(TICK_CYCLES)
    ) u_timers (
        .mclk(mclk),
        .nrst(nrst),
        .cmd(st.sync2[NUM_SET-1:0]),
        .evalCount(evalVec),
        .done(tmrDone)
    );

    fau_lowest_fault #(
        .N(NR)
    ) u_lowest (
        .relays(st.relays),
        .any(anyNow),
        .lowIdx(lowIdx)
    );

    assign relayPad = {{(128 - NR){1'b0}}, st.relays};
    // Zero wait states: read data is caught in the setup cycle
    assign pready = apbReq.psel & apbReq.penable;
    assign wrTake = pready & apbReq.pwrite;

    // Register read decode
    always_comb
    begin
        readMux = 32'h0000_0000;
        mapped = 1'b1;
        case (apbReq.paddr)
            `FAU_OFS_CTRL:
                readMux[`FAU_CTRL_EN_BIT] = st.enable;
            `FAU_OFS_STATUS:
            begin
                readMux[`FAU_STAT_FLAG_BIT] = st.anyFlag;
                readMux[`FAU_STAT_WORD_LSB +: 16] = st.lowWord;
            end
            `FAU_OFS_IRQ_STAT:
                readMux[2:0] = st.irqStatus;
            `FAU_OFS_IRQ_MASK:
                readMux[2:0] = st.irqMask;
            default:
            begin
                if (apbReq.paddr >= `FAU_OFS_RELAY0
                    && apbReq.paddr <= `FAU_OFS_RELAY3
                    && apbReq.paddr[1:0] == 2'h0)
                    readMux = relayPad[32 * (apbReq.paddr[4:2] - 3'h2) +: 32];
                else if (apbReq.paddr >= `FAU_OFS_CHCFG0
                    && apbReq.paddr[1:0] == 2'h0
                    && (apbReq.paddr - `FAU_OFS_CHCFG0) < 8'(4 * NUM_SET))
                begin
                    readMux[`FAU_CFG_TIMER_LSB +: 8] =
                        st.cfg[(apbReq.paddr - `FAU_OFS_CHCFG0) >> 2].timer;
                    readMux[`FAU_CFG_RELAY_LSB +: 7] =
                        st.cfg[(apbReq.paddr - `FAU_OFS_CHCFG0) >> 2].relay;
                    readMux[`FAU_CFG_EVAL_LSB +: 15] =
                        st.cfg[(apbReq.paddr - `FAU_OFS_CHCFG0) >> 2].evalCount;
                end
                else
                    mapped = 1'b0;
            end
        endcase
    end

    always_comb
    begin
        next_st = st;
        setMask = '0;
        clrMask = '0;
        events = 3'h0;
        pulseEdge = 1'b0;
        doClear = 1'b0;
        // Only the second stage of the synchroniser is looked at
        next_st.sync1 = {lowestFaultClearPulse, lowestFaultClear,
            opCycleStrobe, timedFaultSet};
        next_st.sync2 = st.sync1;
        next_st.strobePrev = st.sync2[I_STROBE];
        strobeNow = st.sync2[I_STROBE] & ~st.strobePrev;
        if (strobeNow)
        begin
            // edge against the sample taken at the previous strobe
            pulseEdge = st.sync2[I_PULSE] & ~st.pulsePrev;
            next_st.pulsePrev = st.sync2[I_PULSE];
            doClear = st.sync2[I_CONT] | pulseEdge;
            if (doClear && anyNow)
                clrMask[lowIdx] = 1'b1;
            for (int ch = 0; ch < NUM_SET; ch++)
            begin
                if (tmrDone[ch] && cfgValid(st.cfg[ch]))
                    setMask[st.cfg[ch].relay] = 1'b1;
            end
        end
        // A set in the same cycle as a clear wins
        next_st.relays = (st.relays & ~clrMask) | setMask;
        events[`FAU_IRQ_SET_BIT] = |(setMask & ~st.relays);
        events[`FAU_IRQ_CLR_BIT] = |clrMask;
        // flag gated by the enable bit
        next_st.anyFlag = st.enable & anyNow;
        // word follows the encoder every cycle
        if (st.enable && anyNow)
            next_st.lowWord = `FAU_RELAY_FIRST + {9'h000, lowIdx};
        else
            next_st.lowWord = 16'h0000;
        // APB setup cycle: capture the answer
        if (apbReq.psel && !apbReq.penable)
        begin
            next_st.prdata = apbReq.pwrite ? 32'h0000_0000 : readMux;
            next_st.pslverr = ~mapped;
        end
        if (wrTake && mapped)
        begin
            case (apbReq.paddr)
                `FAU_OFS_CTRL:
                    next_st.enable = apbReq.pwdata[`FAU_CTRL_EN_BIT];
                `FAU_OFS_IRQ_STAT:
                    next_st.irqStatus = st.irqStatus & ~apbReq.pwdata[2:0];
                `FAU_OFS_IRQ_MASK:
                    next_st.irqMask = apbReq.pwdata[2:0];
                default:
                begin
                    if (apbReq.paddr >= `FAU_OFS_CHCFG0)
                    begin
                        next_st.cfg[(apbReq.paddr - `FAU_OFS_CHCFG0) >> 2] =
                            cfgUnpack(apbReq.pwdata);
                        events[`FAU_IRQ_CFG_BIT] =
                            ~cfgValid(cfgUnpack(apbReq.pwdata));
                    end
                end
            endcase
        end
        // New events win over a write-one clear
        next_st.irqStatus = next_st.irqStatus | events;
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            st <= '0;
            st.enable <= `FAU_RST_CTRL;
            st.irqMask <= `FAU_RST_IRQ_MASK;
            for (int ch = 0; ch < NUM_SET; ch++)
                st.cfg[ch].evalCount <= `FAU_RST_EVAL;
        end
        else
            st <= next_st;
    end

    assign prdata = st.prdata;
    assign pslverr = st.pslverr;
    assign anyFaultActiveFlag = st.anyFlag;
    assign lowestActiveFaultWord = st.lowWord;
    assign faultRelays = st.relays;
    assign irq = |(st.irqStatus & st.irqMask);

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    sequence s_clear_req;
        strobeNow && doClear && anyNow && (setMask == '0);
    endsequence

    sequence s_pulse_held;
        strobeNow && st.sync2[I_PULSE] && st.pulsePrev
            && !st.sync2[I_CONT] && (setMask == '0);
    endsequence

    // continuous level seen at a strobe
    sequence s_cont_req;
        strobeNow && st.sync2[I_CONT] && anyNow && (setMask == '0);
    endsequence

    // first strobe after the pulse level rose
    sequence s_pulse_rise;
        strobeNow && st.sync2[I_PULSE] && !st.pulsePrev && anyNow
            && (setMask == '0);
    endsequence

    a_flag_any_on: assert property (
        st.enable && anyNow |=> anyFaultActiveFlag)
        else $error("flag low with relay on");

    a_flag_disabled: assert property (
        !st.enable |=> !anyFaultActiveFlag
            && lowestActiveFaultWord == 16'h0000)
        else $error("output valid while disabled");

    a_idle_zero: assert property (
        !anyNow |=> lowestActiveFaultWord == 16'h0000
            && !anyFaultActiveFlag)
        else $error("idle outputs not zero");

    a_word_lowest: assert property (
        st.enable && anyNow |=> lowestActiveFaultWord
            == `FAU_RELAY_FIRST + {9'h000, $past(lowIdx)})
        else $error("word not lowest relay");

    a_clear_lowest: assert property (
        s_clear_req |=> !st.relays[$past(lowIdx)]
            && $countones(st.relays) == $countones($past(st.relays)) - 1)
        else $error("clear not lowest only");

    a_pulse_once: assert property (
        s_pulse_held |=> st.relays == $past(st.relays))
        else $error("pulse form cleared twice");

    // A timer restarted after a release must count from zero again
    a_timer_release: assert property (
        !st.sync2[0] ##1 st.sync2[0] |-> !tmrDone[0])
        else $error("timer kept after release");

    a_set_relay: assert property (
        strobeNow && tmrDone[0] && cfgValid(st.cfg[0])
            |=> st.relays[$past(st.cfg[0].relay)])
        else $error("relay not set");

    a_cont_repeat: assert property (
        s_clear_req ##1 (!strobeNow)[*1]
            |-> $countones(st.relays) < $countones($past(st.relays, 2)))
        else $error("continuous clear missed");

    a_cont_each: assert property (
        s_cont_req |=> $countones(st.relays)
            == $countones($past(st.relays)) - 1)
        else $error("continuous clear skipped a cycle");

    a_pulse_first: assert property (
        s_pulse_rise |=> $countones(st.relays)
            == $countones($past(st.relays)) - 1)
        else $error("pulse form did not clear");

    a_relay_still: assert property (
        !strobeNow |=> st.relays == $past(st.relays))
        else $error("relays moved between strobes");

    a_set_event: assert property (
        (setMask & ~st.relays) != '0 |=> st.irqStatus[`FAU_IRQ_SET_BIT])
        else $error("set event not flagged");

endmodule
`default_nettype wire

// file: bench/fau_scan_model.sv
// Purpose: Scan strobe source standing in for the sequence program
// Assumes: One operation cycle every PERIOD mclk
// Notes: Strobe stays high and low long enough to pass the synchroniser
`timescale 1ns/1ps
`default_nettype none

module fau_scan_model #(
    parameter int PERIOD = 10
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Scan strobe
    output logic opCycleStrobe
);
    int cnt;

    // one strobe per cycle
    // Four high, rest low: shorter pulses could be lost in the two flops
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt <= 0;
            opCycleStrobe <= 1'b0;
        end
        else
        begin
            cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
            opCycleStrobe <= (cnt < 4);
        end
    end
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// Purpose: Self-checking bench of the fault annunciator unit
// Assumes: Short evaluation tick of 8 mclk, scan every 10 mclk
// Notes: Timed-set cases run from a table, clears are hand-written
`timescale 1ns/1ps
`default_nettype none
`include "fau_cfg.svh"

module tb_top;
    import fau_pkg::*;

    `define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
        n_errors++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end

    typedef struct packed {
        logic [1:0] ch;
        logic [14:0] ev;
        logic [6:0] rel;
        logic [7:0] hold;
        logic exp;
    } fau_row_s;

    logic mclk = 1'b0;
    logic nrst = 1'b0;
    fau_apb_req_s apbReq = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic opCycleStrobe;
    logic [3:0] timedFaultSet = 4'h0;
    logic lowestFaultClear = 1'b0;
    logic lowestFaultClearPulse = 1'b0;
    logic anyFaultActiveFlag;
    logic [15:0] lowestActiveFaultWord;
    logic [99:0] faultRelays;
    logic irq;
    logic [99:0] expRelays = '0;
    logic [31:0] rd;
    logic err;
    int n_errors = 0;
    int compares = 0;
    // Row four: a zero count is refused. Last two rows: early release,
    // then a retry that only a kept count would complete
    fau_row_s rows [6] = '{
        '{2'h0, 15'h0003, 7'h05, 8'h3c, 1'b1},
        '{2'h1, 15'h0001, 7'h00, 8'h28, 1'b1},
        '{2'h2, 15'h0002, 7'h63, 8'h32, 1'b1},
        '{2'h1, 15'h0000, 7'h10, 8'h28, 1'b0},
        '{2'h3, 15'h0004, 7'h28, 8'h1c, 1'b0},
        '{2'h3, 15'h0004, 7'h28, 8'h1c, 1'b0}};

    always #50 mclk = ~mclk;

    fau_top #(.NUM_SET(4), .TICK_CYCLES(8)) uut (
        .mclk(mclk), .nrst(nrst), .apbReq(apbReq), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .opCycleStrobe(opCycleStrobe),
        .timedFaultSet(timedFaultSet), .lowestFaultClear(lowestFaultClear),
        .lowestFaultClearPulse(lowestFaultClearPulse),
        .anyFaultActiveFlag(anyFaultActiveFlag),
        .lowestActiveFaultWord(lowestActiveFaultWord),
        .faultRelays(faultRelays), .irq(irq));

    fau_scan_model #(.PERIOD(10)) scan (
        .mclk(mclk), .nrst(nrst), .opCycleStrobe(opCycleStrobe));

    function automatic logic [15:0] lowWord(input logic [99:0] r);
        logic [15:0] w;
        w = 16'h0000;
        for (int i = 99; i >= 0; i--)
            if (r[i]) w = `FAU_RELAY_FIRST + 16'(i);
        return w;
    endfunction

    task automatic tally_and_finish();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        int n;
        @(posedge mclk);
        apbReq.psel <= 1'b1;
        apbReq.penable <= 1'b0;
        apbReq.pwrite <= wr;
        apbReq.paddr <= a;
        apbReq.pwdata <= wd;
        @(posedge mclk);
        apbReq.penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            n_errors++;
            tally_and_finish();
        end
        rd = prdata;
        err = pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
    endtask

    // Relays are sampled once per mclk, so a double clear shows up
    task automatic waitChange();
        int n;
        n = 0;
        while (faultRelays === expRelays && n < 60)
        begin
            @(posedge mclk);
            n++;
        end
        if (n >= 60)
        begin
            n_errors++;
            tally_and_finish();
        end
    endtask

    initial
    begin
        repeat (5) @(posedge mclk);
        nrst <= 1'b1;
        `CHK("flag", 1'b0, anyFaultActiveFlag)
        apb(1'b0, `FAU_OFS_CTRL, 32'h0);
        `CHK("ctrl", 32'h00000000, rd)
        apb(1'b0, `FAU_OFS_CHCFG0, 32'h0);
        `CHK("cfg0", 32'h00000001, rd)
        // largest count, last timer and last relay
        apb(1'b1, `FAU_OFS_CHCFG0 + 8'h0c, 32'hc7637fff);
        apb(1'b0, `FAU_OFS_CHCFG0 + 8'h0c, 32'h0);
        `CHK("cfg3", 32'hc7637fff, rd)
        apb(1'b0, 8'h80, 32'h0);
        `CHK("slverr", 1'b1, err)
        `CHK("unmapped", 32'h00000000, rd)
        apb(1'b1, `FAU_OFS_CTRL, 32'h1);
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b1, 8'h20 + {4'h0, rows[i].ch, 2'b00}, {6'h00, rows[i].ch,
                1'b0, rows[i].rel, 1'b0, rows[i].ev});
            timedFaultSet[rows[i].ch] <= 1'b1;
            repeat (rows[i].hold) @(posedge mclk);
            timedFaultSet[rows[i].ch] <= 1'b0;
            repeat (15) @(posedge mclk);
            expRelays[rows[i].rel] = expRelays[rows[i].rel] | rows[i].exp;
            `CHK("relays", expRelays, faultRelays)
            `CHK("word", lowWord(expRelays), lowestActiveFaultWord)
            `CHK("flag", |expRelays, anyFaultActiveFlag)
        end
        apb(1'b0, `FAU_OFS_STATUS, 32'h0);
        `CHK("status", 32'h03840001, rd)
        apb(1'b0, `FAU_OFS_RELAY3, 32'h0);
        `CHK("relay3", 32'h00000008, rd)
        // Set events plus the refused zero-count setting
        apb(1'b0, `FAU_OFS_IRQ_STAT, 32'h0);
        `CHK("irqstat", 32'h00000005, rd)
        `CHK("irq", 1'b0, irq)
        apb(1'b1, `FAU_OFS_IRQ_MASK, 32'h1);
        repeat (2) @(posedge mclk);
        `CHK("irq", 1'b1, irq)
        apb(1'b1, `FAU_OFS_IRQ_STAT, 32'h1);
        repeat (2) @(posedge mclk);
        `CHK("irq", 1'b0, irq)
        apb(1'b1, `FAU_OFS_CTRL, 32'h0);
        repeat (3) @(posedge mclk);
        `CHK("flag", 1'b0, anyFaultActiveFlag)
        `CHK("word", 16'h0000, lowestActiveFaultWord)
        apb(1'b1, `FAU_OFS_CTRL, 32'h1);
        repeat (3) @(posedge mclk);
        `CHK("word", 16'h0384, lowestActiveFaultWord)
        lowestFaultClearPulse <= 1'b1;
        waitChange();
        expRelays[0] = 1'b0;
        repeat (2) @(posedge mclk);
        `CHK("relays", expRelays, faultRelays)
        repeat (40) @(posedge mclk);
        `CHK("relays", expRelays, faultRelays)
        `CHK("word", 16'h0389, lowestActiveFaultWord)
        lowestFaultClearPulse <= 1'b0;
        lowestFaultClear <= 1'b1;
        waitChange();
        expRelays[5] = 1'b0;
        repeat (2) @(posedge mclk);
        `CHK("relays", expRelays, faultRelays)
        waitChange();
        expRelays[99] = 1'b0;
        repeat (3) @(posedge mclk);
        `CHK("relays", expRelays, faultRelays)
        `CHK("flag", 1'b0, anyFaultActiveFlag)
        `CHK("word", 16'h0000, lowestActiveFaultWord)
        lowestFaultClear <= 1'b0;
        // Write-one clear left the refused-setting bit alone
        apb(1'b0, `FAU_OFS_IRQ_STAT, 32'h0);
        `CHK("irqstat", 32'h00000006, rd)
        // Mid-run reset: settings and sticky bits go back
        nrst <= 1'b0;
        repeat (2) @(posedge mclk);
        `CHK("flag", 1'b0, anyFaultActiveFlag)
        nrst <= 1'b1;
        apb(1'b0, `FAU_OFS_CHCFG0 + 8'h0c, 32'h0);
        `CHK("cfg3", 32'h00000001, rd)
        apb(1'b0, `FAU_OFS_CTRL, 32'h0);
        `CHK("ctrl", 32'h00000000, rd)
        apb(1'b0, `FAU_OFS_IRQ_STAT, 32'h0);
        `CHK("irqstat", 32'h00000000, rd)
        tally_and_finish();
    end
endmodule
`default_nettype wire
